/* File: hw/dscr_defs.svh */
// constants of the drive start-up configuration register bank
//
// Operation
// (RULE_01) start mode: 0 none, 1 torque loop, 2 velocity loop, 3 gearing; default 0
// (RULE_02) start mode launches on entering power-stage-active, only under local control
// (RULE_03) torque and velocity start modes take reference from analog input one
// (RULE_04) port role: 0 quadrature in, 1 step/direction in, 2 emulated out; default 0
// (RULE_05) quadrature input counts every edge of both channels, accepts a marker
// (RULE_06) new port role is stored but applies only after next power-up
// (RULE_07) node number accepts 1 through 127, default 127
// (RULE_08) new node number applies after power-up or network management reset
// (RULE_09) bit rate accepts 50, 125, 250, 500, 1000 kbit/s; default 125
// (RULE_10) new bit rate applies only after power-up; link keeps old rate
// (RULE_11) node number and bit rate govern only when canopen source selected
// (RULE_12) integrator gives every node on a network a unique node number
// (RULE_13) control source: 0 undefined, 1 local, 2 canopen, 3 modbus; at power-up
// (RULE_14) out-of-range writes are rejected and the stored value stays
// (RULE_15) stored and active copies; active loads from stored at power-up
`ifndef DSCR_DEFS_SVH
`define DSCR_DEFS_SVH

// ****************************************************************
// parameter addresses
// ****************************************************************
`define DSCR_OFS_CTRL_SRC 16'h0502
`define DSCR_OFS_POS_ROLE 16'h0504
`define DSCR_OFS_START_MODE 16'h0506
`define DSCR_OFS_NODE 16'h1704
`define DSCR_OFS_RATE 16'h1706

// ****************************************************************
// reset values and limits
// ****************************************************************
`define DSCR_RST_CTRL_SRC 2'h0
`define DSCR_RST_POS_ROLE 2'h0
`define DSCR_RST_START_MODE 2'h0
`define DSCR_RST_NODE 7'h7F
`define DSCR_RST_RATE 16'h007D
`define DSCR_NODE_MIN 16'h0001
`define DSCR_NODE_MAX 16'h007F
`define DSCR_SRC_MAX 16'h0003
`define DSCR_MODE_MAX 16'h0003
`define DSCR_ROLE_MAX 16'h0002

// ****************************************************************
// permitted bit rates in kbit/s
// ****************************************************************
`define DSCR_RATE_50 16'h0032
`define DSCR_RATE_125 16'h007D
`define DSCR_RATE_250 16'h00FA
`define DSCR_RATE_500 16'h01F4
`define DSCR_RATE_1000 16'h03E8

// ****************************************************************
// encodings
// ****************************************************************
`define DSCR_ENC_0 2'h0
`define DSCR_ENC_1 2'h1
`define DSCR_ENC_2 2'h2
`define DSCR_ENC_3 2'h3

`endif

/* File: hw/dscr_pkg.sv */
// types of the drive start-up configuration register bank
`include "dscr_defs.svh"
package dscr_pkg;

  typedef enum logic [1:0] {
    DSCR_MODE_NONE = `DSCR_ENC_0,
    DSCR_MODE_TORQUE = `DSCR_ENC_1,
    DSCR_MODE_VELOCITY = `DSCR_ENC_2,
    DSCR_MODE_GEARING = `DSCR_ENC_3
  } dscr_start_mode_t;

  typedef enum logic [1:0] {
    DSCR_ROLE_QUAD_IN = `DSCR_ENC_0,
    DSCR_ROLE_STEP_IN = `DSCR_ENC_1,
    DSCR_ROLE_EMUL_OUT = `DSCR_ENC_2,
    DSCR_ROLE_BAD = `DSCR_ENC_3
  } dscr_pos_role_t;

  typedef enum logic [1:0] {
    DSCR_SRC_UNDEF = `DSCR_ENC_0,
    DSCR_SRC_LOCAL = `DSCR_ENC_1,
    DSCR_SRC_CANOPEN = `DSCR_ENC_2,
    DSCR_SRC_MODBUS = `DSCR_ENC_3
  } dscr_ctrl_src_t;

  typedef enum logic {
    DSCR_LAUNCH_WAIT,
    DSCR_LAUNCH_RUN
  } dscr_launch_state_t;

endpackage : dscr_pkg

/* File: hw/dscr_pos_counter.sv */
// position interface input counter: pin synchronisers and edge counting
`timescale 1ns/1ps
`include "dscr_defs.svh"
module dscr_pos_counter
  import dscr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire dscr_pos_role_t role_i,
  input wire logic chan_a_i,
  input wire logic chan_b_i,
  input wire logic marker_i,
  output logic [31:0] count_o,
  output logic marker_seen_o
);

  // ****************************************************************
  // three-stage pin synchronisers, change taken when stages 2 and 3 agree
  // ****************************************************************
  logic [2:0] sy1, sy2, sy3, flt, next_flt;
  logic [31:0] next_count;
  logic next_marker;
  logic quad_a, quad_b, quad_a_old, quad_b_old;

  always_comb begin
    next_flt = ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & flt);
  end

  assign quad_a = next_flt[0];
  assign quad_b = next_flt[1];
  assign quad_a_old = flt[0];
  assign quad_b_old = flt[1];

  // ****************************************************************
  // counting
  // ****************************************************************
  always_comb begin
    next_count = count_o;
    next_marker = 1'b0;
    if (role_i == DSCR_ROLE_QUAD_IN) begin
      // one count per edge of either channel, four per line [RULE_05]
      if ((quad_a ^ quad_a_old) != (quad_b ^ quad_b_old)) begin
        if (quad_a ^ quad_b_old) begin
          next_count = count_o + 32'h0000_0001;
        end else begin
          next_count = count_o - 32'h0000_0001;
        end
      end
      next_marker = next_flt[2] & ~flt[2]; // [RULE_05]
    end else if (role_i == DSCR_ROLE_STEP_IN) begin
      // step on rising pulse edge, only while the gate line is high
      if (quad_a & ~quad_a_old & next_flt[2]) begin
        next_count = quad_b ? count_o - 32'h0000_0001
                            : count_o + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sy1 <= 3'h0;
      sy2 <= 3'h0;
      sy3 <= 3'h0;
      flt <= 3'h0;
      count_o <= 32'h0000_0000;
      marker_seen_o <= 1'b0;
    end else begin
      sy1 <= {marker_i, chan_b_i, chan_a_i};
      sy2 <= sy1;
      sy3 <= sy2;
      flt <= next_flt;
      count_o <= next_count;
      marker_seen_o <= next_marker;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_quad_single_edge;
    (role_i == DSCR_ROLE_QUAD_IN) && (flt[0] != next_flt[0])
      && (flt[1] == next_flt[1])
      |=> count_o != $past(count_o);
  endproperty
  a_quad_single_edge: assert property (p_quad_single_edge) // [RULE_05]
    else $error("quadrature edge not counted");

  property p_marker_only_quad;
    marker_seen_o |-> $past(role_i) == DSCR_ROLE_QUAD_IN;
  endproperty
  a_marker_only_quad: assert property (p_marker_only_quad) // [RULE_05]
    else $error("marker reported outside quadrature role");

endmodule : dscr_pos_counter

/* File: hw/dscr_top.sv */
// drive start-up configuration bank: stored and active parameter copies
`timescale 1ns/1ps
`include "dscr_defs.svh"
module dscr_top
  import dscr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic par_wr_i,
  input wire logic par_rd_i,
  input wire logic [15:0] par_addr_i,
  input wire logic [15:0] par_wdata_i,
  output logic [15:0] par_rdata_o,
  output logic par_ack_o,
  output logic par_err_o,
  input wire logic nmt_reset_i,
  input wire logic op_enabled_i,
  output logic start_req_o,
  output dscr_start_mode_t start_mode_o,
  output logic ref_from_analog_one_o,
  output dscr_ctrl_src_t control_source_o,
  output logic fieldbus_enable_o,
  output logic [6:0] fieldbus_node_number_o,
  output logic [15:0] fieldbus_bit_rate_o,
  output dscr_pos_role_t position_port_role_o,
  input wire logic pos_chan_a_i,
  input wire logic pos_chan_b_i,
  input wire logic pos_marker_i,
  output logic pos_chan_a_o,
  output logic pos_chan_b_o,
  output logic pos_marker_o,
  output logic pos_chan_a_oe_o,
  output logic pos_chan_b_oe_o,
  output logic pos_marker_oe_o,
  input wire logic emul_step_i,
  input wire logic emul_dir_i,
  input wire logic emul_marker_i,
  output logic [31:0] position_count_o,
  output logic marker_seen_o
);

  // ****************************************************************
  // persistent copies, active copies
  // ****************************************************************
  // initialisers stand for the factory defaults of the persistent memory
  dscr_ctrl_src_t st_src = dscr_ctrl_src_t'(`DSCR_RST_CTRL_SRC);
  dscr_pos_role_t st_role = dscr_pos_role_t'(`DSCR_RST_POS_ROLE);
  dscr_start_mode_t st_mode = dscr_start_mode_t'(`DSCR_RST_START_MODE);
  logic [6:0] st_node = `DSCR_RST_NODE;
  logic [15:0] st_rate = `DSCR_RST_RATE;
  dscr_ctrl_src_t act_src, next_st_src, next_act_src;
  dscr_pos_role_t act_role, next_st_role, next_act_role;
  dscr_start_mode_t act_mode, next_st_mode, next_act_mode;
  logic [6:0] act_node, next_st_node, next_act_node;
  logic [15:0] act_rate, next_st_rate, next_act_rate;
  logic loaded, next_loaded;
  logic [15:0] next_rdata;
  logic next_ack, next_err;
  logic addr_hit, value_ok;

  // address decode and value check of a write
  always_comb begin
    addr_hit = 1'b1;
    value_ok = 1'b0;
    unique case (par_addr_i)
      `DSCR_OFS_CTRL_SRC: value_ok = par_wdata_i <= `DSCR_SRC_MAX; // [RULE_13]
      `DSCR_OFS_POS_ROLE: value_ok = par_wdata_i <= `DSCR_ROLE_MAX; // [RULE_04]
      `DSCR_OFS_START_MODE: value_ok = par_wdata_i <= `DSCR_MODE_MAX; // [RULE_01]
      `DSCR_OFS_NODE: value_ok = (par_wdata_i >= `DSCR_NODE_MIN)
                                 && (par_wdata_i <= `DSCR_NODE_MAX); // [RULE_07]
      `DSCR_OFS_RATE: value_ok = (par_wdata_i == `DSCR_RATE_50)
                                 || (par_wdata_i == `DSCR_RATE_125)
                                 || (par_wdata_i == `DSCR_RATE_250)
                                 || (par_wdata_i == `DSCR_RATE_500)
                                 || (par_wdata_i == `DSCR_RATE_1000); // [RULE_09]
      default: addr_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // parameter access
  // ****************************************************************
  always_comb begin
    next_st_src = st_src;
    next_st_role = st_role;
    next_st_mode = st_mode;
    next_st_node = st_node;
    next_st_rate = st_rate;
    next_rdata = par_rdata_o;
    next_ack = par_wr_i | par_rd_i;
    next_err = 1'b0;
    if (par_wr_i) begin
      // rejected writes leave the stored copy alone [RULE_14]
      next_err = ~(addr_hit & value_ok);
      if (addr_hit && value_ok) begin
        unique case (par_addr_i)
          `DSCR_OFS_CTRL_SRC: next_st_src = dscr_ctrl_src_t'(par_wdata_i[1:0]);
          `DSCR_OFS_POS_ROLE: next_st_role = dscr_pos_role_t'(par_wdata_i[1:0]);
          `DSCR_OFS_START_MODE:
            next_st_mode = dscr_start_mode_t'(par_wdata_i[1:0]);
          `DSCR_OFS_NODE: next_st_node = par_wdata_i[6:0];
          default: next_st_rate = par_wdata_i;
        endcase
      end
    end else if (par_rd_i) begin
      next_err = ~addr_hit;
      // reads show the stored copy, which is what the next power-up uses
      unique case (par_addr_i)
        `DSCR_OFS_CTRL_SRC: next_rdata = {14'h0000, st_src};
        `DSCR_OFS_POS_ROLE: next_rdata = {14'h0000, st_role};
        `DSCR_OFS_START_MODE: next_rdata = {14'h0000, st_mode};
        `DSCR_OFS_NODE: next_rdata = {9'h000, st_node};
        `DSCR_OFS_RATE: next_rdata = st_rate;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // active copies: loaded once after power-up, node number also on network reset
  // ****************************************************************
  always_comb begin
    next_loaded = 1'b1;
    next_act_src = act_src;
    next_act_role = act_role;
    next_act_mode = act_mode;
    next_act_node = act_node;
    next_act_rate = act_rate;
    if (!loaded) begin
      next_act_src = st_src; // [RULE_13] [RULE_15]
      next_act_role = st_role; // [RULE_06] [RULE_15]
      next_act_mode = st_mode; // [RULE_15]
      next_act_node = st_node; // [RULE_08] [RULE_15]
      next_act_rate = st_rate; // [RULE_10] [RULE_15]
    end else if (nmt_reset_i) begin
      next_act_node = st_node; // [RULE_08]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_src <= dscr_ctrl_src_t'(`DSCR_RST_CTRL_SRC);
      act_role <= dscr_pos_role_t'(`DSCR_RST_POS_ROLE);
      act_mode <= dscr_start_mode_t'(`DSCR_RST_START_MODE);
      act_node <= `DSCR_RST_NODE;
      act_rate <= `DSCR_RST_RATE;
      loaded <= 1'b0;
      par_rdata_o <= 16'h0000;
      par_ack_o <= 1'b0;
      par_err_o <= 1'b0;
    end else begin
      act_src <= next_act_src;
      act_role <= next_act_role;
      act_mode <= next_act_mode;
      act_node <= next_act_node;
      act_rate <= next_act_rate;
      loaded <= next_loaded;
      par_rdata_o <= next_rdata;
      par_ack_o <= next_ack;
      par_err_o <= next_err;
    end
  end

  // no reset: a power-up must not wipe the stored copy [RULE_15]
  always_ff @(posedge ref_clk_i) begin
    st_src <= next_st_src;
    st_role <= next_st_role;
    st_mode <= next_st_mode;
    st_node <= next_st_node;
    st_rate <= next_st_rate;
  end

  // ****************************************************************
  // start-mode launcher and fieldbus settings
  // ****************************************************************
  dscr_launch_state_t state, next_state;
  logic op_enabled_d, next_start_req, next_ref_ana, next_fb_en;
  dscr_start_mode_t next_start_mode;
  logic [6:0] next_fb_node;
  logic [15:0] next_fb_rate;

  always_comb begin
    next_state = state;
    next_start_req = 1'b0;
    next_start_mode = start_mode_o;
    unique case (state)
      DSCR_LAUNCH_WAIT: begin
        if (op_enabled_i && !op_enabled_d && loaded
            && act_src == DSCR_SRC_LOCAL
            && act_mode != DSCR_MODE_NONE) begin // [RULE_02]
          next_state = DSCR_LAUNCH_RUN;
          next_start_req = 1'b1;
          next_start_mode = act_mode;
        end
      end
      DSCR_LAUNCH_RUN: begin
        if (!op_enabled_i) begin
          next_state = DSCR_LAUNCH_WAIT;
          next_start_mode = DSCR_MODE_NONE;
        end
      end
    endcase
    next_ref_ana = (next_start_mode == DSCR_MODE_TORQUE)
                   || (next_start_mode == DSCR_MODE_VELOCITY); // [RULE_03]
    // node and rate steer the link only under canopen control [RULE_11]
    next_fb_en = loaded && act_src == DSCR_SRC_CANOPEN;
    next_fb_node = next_fb_en ? act_node : 7'h00;
    next_fb_rate = next_fb_en ? act_rate : 16'h0000;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= DSCR_LAUNCH_WAIT;
      op_enabled_d <= 1'b0;
      start_req_o <= 1'b0;
      start_mode_o <= DSCR_MODE_NONE;
      ref_from_analog_one_o <= 1'b0;
      control_source_o <= DSCR_SRC_UNDEF;
      fieldbus_enable_o <= 1'b0;
      fieldbus_node_number_o <= 7'h00;
      fieldbus_bit_rate_o <= 16'h0000;
      position_port_role_o <= DSCR_ROLE_QUAD_IN;
    end else begin
      state <= next_state;
      op_enabled_d <= op_enabled_i;
      start_req_o <= next_start_req;
      start_mode_o <= next_start_mode;
      ref_from_analog_one_o <= next_ref_ana;
      control_source_o <= act_src;
      fieldbus_enable_o <= next_fb_en;
      fieldbus_node_number_o <= next_fb_node;
      fieldbus_bit_rate_o <= next_fb_rate;
      position_port_role_o <= act_role;
    end
  end

  // ****************************************************************
  // position interface: emulated encoder driver and input counter
  // ****************************************************************
  logic [1:0] emul_phase, next_emul_phase;
  logic emul_on;

  assign emul_on = act_role == DSCR_ROLE_EMUL_OUT; // [RULE_04] [RULE_06]

  always_comb begin
    next_emul_phase = emul_phase;
    if (emul_on && emul_step_i) begin
      next_emul_phase = emul_dir_i ? emul_phase - 2'h1 : emul_phase + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      emul_phase <= 2'h0;
      pos_chan_a_o <= 1'b0;
      pos_chan_b_o <= 1'b0;
      pos_marker_o <= 1'b0;
      pos_chan_a_oe_o <= 1'b0;
      pos_chan_b_oe_o <= 1'b0;
      pos_marker_oe_o <= 1'b0;
    end else begin
      emul_phase <= next_emul_phase;
      // binary phase driven out in gray order so only one channel moves per step
      pos_chan_a_o <= next_emul_phase[1];
      pos_chan_b_o <= next_emul_phase[1] ^ next_emul_phase[0];
      pos_marker_o <= emul_on & emul_marker_i;
      pos_chan_a_oe_o <= emul_on;
      pos_chan_b_oe_o <= emul_on;
      pos_marker_oe_o <= emul_on;
    end
  end

  dscr_pos_counter u_counter (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .role_i(act_role),
    .chan_a_i(pos_chan_a_i),
    .chan_b_i(pos_chan_b_i),
    .marker_i(pos_marker_i),
    .count_o(position_count_o),
    .marker_seen_o(marker_seen_o)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_bad_node_write;
    par_wr_i && par_addr_i == `DSCR_OFS_NODE
      && (par_wdata_i < `DSCR_NODE_MIN || par_wdata_i > `DSCR_NODE_MAX);
  endsequence
  property p_reject_node;
    s_bad_node_write |=> par_err_o && par_ack_o && $stable(st_node);
  endproperty
  a_reject_node: assert property (p_reject_node) // [RULE_14]
    else $error("bad node number write not rejected");

  property p_node_range;
    st_node != 7'h00 && act_node != 7'h00;
  endproperty
  a_node_range: assert property (p_node_range) // [RULE_07]
    else $error("node number outside 1 to 127");

  property p_rate_set;
    st_rate == `DSCR_RATE_50 || st_rate == `DSCR_RATE_125
      || st_rate == `DSCR_RATE_250 || st_rate == `DSCR_RATE_500
      || st_rate == `DSCR_RATE_1000;
  endproperty
  a_rate_set: assert property (p_rate_set) // [RULE_09]
    else $error("stored bit rate not permitted");

  sequence s_launch_cause;
    state == DSCR_LAUNCH_WAIT && $rose(op_enabled_i) && loaded
      && act_src == DSCR_SRC_LOCAL && act_mode != DSCR_MODE_NONE;
  endsequence
  sequence s_launch_effect;
    start_req_o && start_mode_o == $past(act_mode) ##1 !start_req_o;
  endsequence
  property p_launch;
    s_launch_cause |=> s_launch_effect;
  endproperty
  a_launch: assert property (p_launch) // [RULE_02]
    else $error("start mode not launched");

  property p_launch_local_only;
    start_req_o |-> $past(act_src) == DSCR_SRC_LOCAL;
  endproperty
  a_launch_local_only: assert property (p_launch_local_only) // [RULE_02]
    else $error("start mode launched without local control");

  property p_analog_ref;
    ref_from_analog_one_o == (start_mode_o == DSCR_MODE_TORQUE
                              || start_mode_o == DSCR_MODE_VELOCITY);
  endproperty
  a_analog_ref: assert property (p_analog_ref) // [RULE_03]
    else $error("analog reference select wrong");

  property p_active_frozen;
    loaded |=> $stable(act_role) && $stable(act_rate) && $stable(act_src);
  endproperty
  a_active_frozen: assert property (p_active_frozen) // [RULE_06] [RULE_10]
    else $error("active setting changed without power-up");

  property p_nmt_node;
    loaded && nmt_reset_i |=> act_node == $past(st_node);
  endproperty
  a_nmt_node: assert property (p_nmt_node) // [RULE_08]
    else $error("node number not reloaded on network reset");

  property p_powerup_load;
    $rose(loaded) |-> act_rate == $past(st_rate)
      && act_node == $past(st_node) && act_mode == $past(st_mode);
  endproperty
  a_powerup_load: assert property (p_powerup_load) // [RULE_15]
    else $error("active copy not loaded at power-up");

  property p_fieldbus_gate;
    !fieldbus_enable_o |-> fieldbus_node_number_o == 7'h00
      && fieldbus_bit_rate_o == 16'h0000;
  endproperty
  a_fieldbus_gate: assert property (p_fieldbus_gate) // [RULE_11]
    else $error("fieldbus settings driven outside canopen control");

endmodule : dscr_top

/* File: verif/dscr_master_model.sv */
// fieldbus master model issuing parameter requests
`timescale 1ns/1ps
module dscr_master_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] par_rdata_i,
  input wire logic par_ack_i,
  input wire logic par_err_i,
  output logic par_wr_o,
  output logic par_rd_o,
  output logic [15:0] par_addr_o,
  output logic [15:0] par_wdata_o
);
  initial begin
    par_wr_o = 1'b0;
    par_rd_o = 1'b0;
    par_addr_o = 16'h0000;
    par_wdata_o = 16'h0000;
  end
  // one node only on this network, so its number is unique
  task automatic xfer(input logic w, input logic [15:0] a, d,
      output logic [15:0] q, output logic e, k);
    @(posedge ref_clk_i);
    #1;
    par_wr_o = w;
    par_rd_o = !w;
    par_addr_o = a;
    par_wdata_o = d;
    @(posedge ref_clk_i);
    #1;
    par_wr_o = 1'b0;
    par_rd_o = 1'b0;
    // idle bus inverted so stale values never match
    par_addr_o = ~a;
    par_wdata_o = ~d;
    q = par_rdata_i;
    e = par_err_i;
    k = par_ack_i;
  endtask : xfer
endmodule : dscr_master_model

/* File: verif/test_drive_startup_config_regs.sv */
// self-checking bench of the start-up configuration bank
`timescale 1ns/1ps
module test_drive_startup_config_regs;
  import dscr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic nmt = 1'b0, op_en = 1'b0, qa = 1'b0, qb = 1'b0, qm = 1'b0;
  logic es = 1'b0;
  logic wr, rd, ack, err, sreq, ana, fen, qmk;
  logic [15:0] addr, wdata, rdata, rate;
  logic [6:0] node;
  logic [31:0] cnt;
  logic [2:0] oe, eo;
  dscr_start_mode_t smode;
  dscr_ctrl_src_t src;
  dscr_pos_role_t role;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int marks = 0;
  int st [5] = '{0, 0, 0, 127, 125};
  int act [5];
  int rl [5] = '{50, 125, 250, 500, 1000};
  logic [15:0] ofs [5] = '{16'h0502, 16'h0504, 16'h0506, 16'h1704, 16'h1706};
  dscr_master_model m (.ref_clk_i(ref_clk_i), .par_rdata_i(rdata),
    .par_ack_i(ack), .par_err_i(err), .par_wr_o(wr), .par_rd_o(rd),
    .par_addr_o(addr), .par_wdata_o(wdata));
  dscr_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .par_wr_i(wr),
    .par_rd_i(rd), .par_addr_i(addr), .par_wdata_i(wdata),
    .par_rdata_o(rdata), .par_ack_o(ack), .par_err_o(err),
    .nmt_reset_i(nmt), .op_enabled_i(op_en), .start_req_o(sreq),
    .start_mode_o(smode), .ref_from_analog_one_o(ana),
    .control_source_o(src), .fieldbus_enable_o(fen),
    .fieldbus_node_number_o(node), .fieldbus_bit_rate_o(rate),
    .position_port_role_o(role), .pos_chan_a_i(qa), .pos_chan_b_i(qb),
    .pos_marker_i(qm), .pos_chan_a_o(eo[0]), .pos_chan_b_o(eo[1]),
    .pos_marker_o(eo[2]), .pos_chan_a_oe_o(oe[0]), .pos_chan_b_oe_o(oe[1]),
    .pos_marker_oe_o(oe[2]), .emul_step_i(es), .emul_dir_i(1'b0),
    .emul_marker_i(es), .position_count_o(cnt), .marker_seen_o(qmk));
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (qmk === 1'b1) marks++;
    // whole run needs about 400 cycles
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  function automatic bit ok(int i, int v);
    case (i)
      0, 2: return v <= 3;
      1: return v <= 2;
      3: return v >= 1 && v <= 127;
      default: return v inside {50, 125, 250, 500, 1000};
    endcase
  endfunction : ok
  task automatic acc(input logic w, input int i, input int v);
    logic [15:0] q;
    logic e, k;
    m.xfer(w, ofs[i], 16'(v), q, e, k);
    chk(k, 1'b1);
    if (w) begin
      chk(e, !ok(i, v));
      if (ok(i, v)) st[i] = v;
    end else begin
      chk(e, 1'b0);
      chk(q, st[i]);
    end
  endtask : acc
  task automatic outs();
    chk(src, act[0]);
    chk(role, act[1]);
    chk(oe, act[1] == 2 ? 3'h7 : 3'h0);
    chk(fen, act[0] == 2);
    chk({node, rate}, act[0] == 2 ? {7'(act[3]), 16'(act[4])} : 23'h0);
  endtask : outs
  // reset is power-up: stored copies persist, active copies reload
  task automatic pwr();
    rst_n_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    act = st;
    repeat (4) @(posedge ref_clk_i);
    #1;
    for (int i = 0; i < 5; i++) acc(1'b0, i, 0);
  endtask : pwr
  task automatic step(input logic a, b);
    qa = a;
    qb = b;
    repeat (6) @(posedge ref_clk_i);
    #1;
  endtask : step
  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    int i, v, c0, m0;
    logic [15:0] q;
    logic e, k;
    void'($urandom(32'hEC19));
    pwr();
    for (int n = 0; n < 60; n++) begin
      i = $urandom % 5;
      v = (i == 4 && n[0]) ? rl[$urandom % 5] : $urandom % 130;
      acc(1'b1, i, v);
      acc(1'b0, i, 0);
    end
    m.xfer(1'b0, 16'h1708, 16'h0000, q, e, k);
    chk({k, e, q}, {2'h3, 16'h0000});
    acc(1'b1, 0, 1);
    acc(1'b1, 1, 2);
    acc(1'b1, 2, 2);
    acc(1'b1, 3, 9);
    acc(1'b1, 4, 500);
    nmt = 1'b1;
    @(posedge ref_clk_i);
    #1;
    nmt = 1'b0;
    op_en = 1'b1;
    repeat (4) begin
      @(posedge ref_clk_i);
      #1;
      chk(sreq, 1'b0);
    end
    chk({smode, ana, src, fen}, 6'h00);
    chk({node, rate}, 23'h0);
    chk({role, oe}, 5'h00);
    c0 = cnt;
    m0 = marks;
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    chk(cnt, 32'(c0 + 4));
    qm = 1'b1;
    step(1'b0, 1'b0);
    qm = 1'b0;
    step(1'b0, 1'b0);
    chk(marks - m0, 1);
    op_en = 1'b0;
    pwr();
    outs();
    es = 1'b1;
    @(posedge ref_clk_i);
    #1;
    es = 1'b0;
    chk(eo, 3'h6);
    op_en = 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk({sreq, smode, ana}, 4'hD);
    @(posedge ref_clk_i);
    #1;
    chk({sreq, smode, ana}, 4'h5);
    op_en = 1'b0;
    acc(1'b1, 0, 2);
    acc(1'b1, 1, 1);
    acc(1'b1, 3, 33);
    pwr();
    outs();
    c0 = cnt;
    qm = 1'b1;
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    qm = 1'b0;
    step(1'b0, 1'b0);
    chk(cnt, 32'(c0 + 1));
    acc(1'b1, 3, 5);
    acc(1'b1, 4, 250);
    nmt = 1'b1;
    @(posedge ref_clk_i);
    #1;
    nmt = 1'b0;
    act[3] = st[3];
    @(posedge ref_clk_i);
    #1;
    outs();
    report_and_stop();
  end
endmodule : test_drive_startup_config_regs
